/* pkg/bme_regs.svh */
// register offsets, reset values and fixed constants of the bit manipulation block
`ifndef BME_REGS_SVH
`define BME_REGS_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define BME_OFS_CMD        8'h00
`define BME_OFS_STATUS     8'h04
`define BME_OFS_INT_STAT   8'h08
`define BME_OFS_INT_MASK   8'h0c
`define BME_OFS_DATA_FIRST 8'h40
`define BME_OFS_DATA_LAST  8'h7c

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define BME_RST_WORD       16'h0000
`define BME_RST_MASK       2'h0
`define BME_RST_RDATA      32'h0000_0000

// ---------------------------------------------------------------
// operand constants
// ---------------------------------------------------------------
`define BME_ALL_ONES       16'hffff
`define BME_ALL_ZEROS      16'h0000
`define BME_TBL_N_MIN      4'h1
`define BME_TBL_N_MAX      4'h8
`define BME_WORD_SHIFT     4'h0
`define BME_ADDR_LSB_ZERO  2'h0

`endif

/* pkg/bme_pkg.sv */
// types shared by the bit manipulation block
`default_nettype none
package bme_pkg;

  // -------------------------------------------------------------
  // instruction codes
  // -------------------------------------------------------------
  typedef enum logic [2:0] {
    BME_OP_FORCE_HIGH,
    BME_OP_FORCE_LOW,
    BME_OP_CARRY_FORCE_HIGH,
    BME_OP_CARRY_FORCE_LOW,
    BME_OP_PRIORITY_BIT_ENCODER,
    BME_OP_ONE_HOT_EXPANDER,
    BME_OP_POPULATION_TALLY,
    BME_OP_UNUSED
  } bme_op_e;

  // -------------------------------------------------------------
  // command word, status, interrupt and apb request layouts
  // -------------------------------------------------------------
  typedef struct packed {
    logic [3:0] dst_bit;
    logic [3:0] dst_word;
    logic [3:0] src_word;
    logic [3:0] tbl_n;
    logic       word_opnd;
    logic       rung_in;
    bme_op_e    op;
  } bme_cmd_s;

  typedef struct packed {
    logic instruction_fault_flag;
    logic carry_flag;
    logic rung_out;
  } bme_status_s;

  typedef struct packed {
    logic fault_evt;
    logic done_evt;
  } bme_irq_s;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } bme_apb_req_s;

endpackage
`default_nettype wire

/* design/bme_priority_bit_encoder.sv */
// highest set bit of a 2^n bit table
`timescale 1ns/1ps
`default_nettype none

module bme_priority_bit_encoder
(
  // table
  input  wire logic [255:0] tbl,
  input  wire logic [3:0]   tbl_n,
  // result
  output logic              found,
  output logic [7:0]        idx
);
  import bme_pkg::*;

  wire logic [8:0] lim = 9'h1 << tbl_n;

  // lowest to highest so the last hit is the highest
  always_comb
  begin
    found = 1'b0;
    idx   = 8'h00;
    for (int i = 0; i < 256; i++)
    begin
      if (tbl[i] && (9'(i) < lim))
      begin
        found = 1'b1;
        idx   = 8'(i);
      end
    end
  end

endmodule
`default_nettype wire

/* design/bme_population_tally.sv */
// count of set bits in one word
`timescale 1ns/1ps
`default_nettype none

module bme_population_tally
(
  // source word
  input  wire logic [15:0] word,
  // count
  output logic [4:0]       cnt
);
  import bme_pkg::*;

  always_comb
  begin
    cnt = 5'h00;
    for (int i = 0; i < 16; i++)
    begin
      cnt = cnt + 5'(word[i]);
    end
  end

endmodule
`default_nettype wire

/* design/bme_exec.sv */
// bit manipulation execution unit with apb register access
`timescale 1ns/1ps
`default_nettype none
`include "bme_regs.svh"

module bme_exec
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // interrupt
  output logic             irq
);
  import bme_pkg::*;

  localparam int TBL_W = 256;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [TBL_W-1:0] mem_q;
  logic [TBL_W-1:0] mem_d;
  logic             carry_q;
  logic             carry_d;
  logic             fault_q;
  logic             fault_d;
  logic             rung_q;
  logic             rung_d;
  bme_cmd_s         cmd_q;
  bme_irq_s         isr_q;
  bme_irq_s         isr_d;
  bme_irq_s         imr_q;
  logic [31:0]      prdata_q;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  bme_apb_req_s req;
  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

  wire logic acc   = req.psel & req.penable;
  wire logic setup = req.psel & ~req.penable;
  wire logic wr    = acc & req.pwrite;
  wire logic rd    = acc & ~req.pwrite;

  wire logic hit_cmd  = (req.paddr == `BME_OFS_CMD);
  wire logic hit_stat = (req.paddr == `BME_OFS_STATUS);
  wire logic hit_isr  = (req.paddr == `BME_OFS_INT_STAT);
  wire logic hit_imr  = (req.paddr == `BME_OFS_INT_MASK);
  wire logic hit_data = (req.paddr >= `BME_OFS_DATA_FIRST) &&
                        (req.paddr <= `BME_OFS_DATA_LAST) &&
                        (req.paddr[1:0] == `BME_ADDR_LSB_ZERO);
  wire logic hit_any  = hit_cmd | hit_stat | hit_isr | hit_imr | hit_data;

  wire logic [7:0] data_ofs = req.paddr - `BME_OFS_DATA_FIRST;
  wire logic [3:0] data_idx = data_ofs[5:2];
  wire logic [7:0] data_sh  = {data_idx, `BME_WORD_SHIFT};

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  wire logic       exec     = wr & hit_cmd;
  wire bme_cmd_s   cmd      = bme_cmd_s'(req.pwdata[$bits(bme_cmd_s)-1:0]);
  wire logic [7:0] sh_src   = {cmd.src_word, `BME_WORD_SHIFT};
  wire logic [7:0] sh_dst   = {cmd.dst_word, `BME_WORD_SHIFT};
  wire logic [7:0] bit_tgt  = {cmd.dst_word, cmd.dst_bit};
  wire logic       n_ok     = (cmd.tbl_n >= `BME_TBL_N_MIN) && (cmd.tbl_n <= `BME_TBL_N_MAX);
  wire logic [8:0] lim      = 9'h1 << cmd.tbl_n;

  // table view starting at the source word, running over following words
  wire logic [2*TBL_W-1:0] dbl      = {mem_q, mem_q};
  wire logic [TBL_W-1:0]   src_view = dbl[sh_src +: TBL_W];
  wire logic [15:0]        src_val  = src_view[15:0];

  // expander table mask and one-hot pattern, both based at bit zero
  wire logic [7:0]       oh_idx = src_val[7:0] & (lim[7:0] - 8'h01);
  wire logic [TBL_W-1:0] tmask  = ~({TBL_W{1'b1}} << lim);
  wire logic [TBL_W-1:0] oh     = {{(TBL_W-1){1'b0}}, 1'b1} << oh_idx;

  function automatic logic [TBL_W-1:0] rot_l(input logic [TBL_W-1:0] x, input logic [7:0] s);
    logic [2*TBL_W-1:0] w;
    w = {x, x} << s;
    return w[2*TBL_W-1:TBL_W];
  endfunction

  wire logic [TBL_W-1:0] dst_mask = rot_l(tmask, sh_dst);
  wire logic [TBL_W-1:0] dst_oh   = rot_l(oh, sh_dst);

  // ---------------------------------------------------------------
  // operators
  // ---------------------------------------------------------------
  logic       enc_found;
  logic [7:0] enc_idx;
  logic [4:0] tally_cnt;

  bme_priority_bit_encoder u_enc
  (
    .tbl   (src_view),
    .tbl_n (cmd.tbl_n),
    .found (enc_found),
    .idx   (enc_idx)
  );

  bme_population_tally u_tally
  (
    .word (src_val),
    .cnt  (tally_cnt)
  );

  // ---------------------------------------------------------------
  // execution
  // ---------------------------------------------------------------
  logic        ok;
  logic        fault_set;
  bme_status_s stat_w;
  assign stat_w = bme_status_s'(req.pwdata[$bits(bme_status_s)-1:0]);

  always_comb
  begin
    mem_d     = mem_q;
    carry_d   = carry_q;
    ok        = 1'b0;
    fault_set = 1'b0;
    if (wr && hit_data)
    begin
      mem_d[data_sh +: 16] = req.pwdata[15:0];
    end
    if (wr && hit_stat)
    begin
      carry_d = stat_w.carry_flag;
    end
    if (exec && cmd.rung_in)
    begin
      case (cmd.op)
        BME_OP_FORCE_HIGH:
        begin
          if (cmd.word_opnd)
            mem_d[sh_dst +: 16] = `BME_ALL_ONES;
          else
            mem_d[bit_tgt] = 1'b1;
          ok = 1'b1;
        end
        BME_OP_FORCE_LOW:
        begin
          if (cmd.word_opnd)
            mem_d[sh_dst +: 16] = `BME_ALL_ZEROS;
          else
            mem_d[bit_tgt] = 1'b0;
          ok = 1'b1;
        end
        BME_OP_CARRY_FORCE_HIGH:
        begin
          carry_d = 1'b1;
          ok      = 1'b1;
        end
        BME_OP_CARRY_FORCE_LOW:
        begin
          carry_d = 1'b0;
          ok      = 1'b1;
        end
        BME_OP_PRIORITY_BIT_ENCODER:
        begin
          if (n_ok && enc_found)
          begin
            mem_d[sh_dst +: 16] = {8'h00, enc_idx};
            ok = 1'b1;
          end
          else
          begin
            fault_set = 1'b1;
          end
        end
        BME_OP_ONE_HOT_EXPANDER:
        begin
          if (n_ok)
          begin
            mem_d = (mem_q & ~dst_mask) | dst_oh;
            ok    = 1'b1;
          end
          else
          begin
            fault_set = 1'b1;
          end
        end
        BME_OP_POPULATION_TALLY:
        begin
          mem_d[sh_dst +: 16] = {11'h000, tally_cnt};
          ok = 1'b1;
        end
        default:
        begin
          fault_set = 1'b1;
        end
      endcase
    end
  end

  // rung output follows the last executed instruction
  assign rung_d  = exec ? ok : rung_q;
  // hardware set wins over a software clear
  assign fault_d = fault_set ? 1'b1 : ((wr && hit_stat) ? stat_w.instruction_fault_flag : fault_q);

  // ---------------------------------------------------------------
  // interrupt status, cleared by read, events win
  // ---------------------------------------------------------------
  bme_irq_s evt;
  assign evt   = '{fault_evt: fault_set, done_evt: exec};
  assign isr_d = ((rd && hit_isr) ? bme_irq_s'(`BME_RST_MASK) : isr_q) | evt;
  assign irq   = |(isr_q & imr_q);

  // ---------------------------------------------------------------
  // read data, captured in the setup phase
  // ---------------------------------------------------------------
  bme_status_s stat_r;
  assign stat_r = '{instruction_fault_flag: fault_q, carry_flag: carry_q, rung_out: rung_q};

  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = `BME_RST_RDATA;
    if (hit_cmd)
      rd_mux = 32'(cmd_q);
    else if (hit_stat)
      rd_mux = 32'(stat_r);
    else if (hit_isr)
      rd_mux = 32'(isr_q);
    else if (hit_imr)
      rd_mux = 32'(imr_q);
    else if (hit_data)
      rd_mux = {16'h0000, mem_q[data_sh +: 16]};
  end

  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = acc & ~hit_any;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // operands hold their value until rewritten
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mem_q <= {(TBL_W/16){`BME_RST_WORD}};
    else
      mem_q <= mem_d;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      carry_q <= 1'b0;
      fault_q <= 1'b0;
      rung_q  <= 1'b0;
      isr_q   <= bme_irq_s'(`BME_RST_MASK);
    end
    else
    begin
      carry_q <= carry_d;
      fault_q <= fault_d;
      rung_q  <= rung_d;
      isr_q   <= isr_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_q <= '0;
      imr_q <= bme_irq_s'(`BME_RST_MASK);
    end
    else
    begin
      if (exec)
        cmd_q <= cmd;
      if (wr && hit_imr)
        imr_q <= bme_irq_s'(req.pwdata[$bits(bme_irq_s)-1:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= `BME_RST_RDATA;
    else if (setup)
      prdata_q <= rd_mux;
  end

endmodule
`default_nettype wire

/* verification/bme_exec_asserts.sv */
// port checker of the bit manipulation execution unit
`timescale 1ns/1ps
`default_nettype none

module bme_exec_asserts
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // interrupt
  input wire logic        irq
);
  import bme_pkg::*;

  // ---------------------------------------------------------------
  // last command and its destination word address
  // ---------------------------------------------------------------
  bme_cmd_s   cmd_q;
  wire logic  cw = psel & penable & pwrite & (paddr == 8'h00);
  wire logic [7:0] da = 8'h40 + {2'h0, cmd_q.dst_word, 2'h0};

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      cmd_q <= '0;
    else if (cw)
      cmd_q <= bme_cmd_s'(pwdata[20:0]);

  // ---------------------------------------------------------------
  // command followed at once by a read, and apb ready and error flag checks
  // ---------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_cmd(logic [4:0] m, logic [4:0] c);
    cw && ((pwdata[4:0] & m) == c);
  endsequence

  sequence s_rd(logic [7:0] a);
    (psel & !penable & !pwrite & (paddr == a)) ##1 (psel & penable);
  endsequence

  a_carry_set: assert property (s_cmd(5'h0f, 5'h0a) ##1 s_rd(8'h04)
    |-> prdata[1:0] == 2'h3) else $error("carry not set");
  a_carry_clear: assert property (s_cmd(5'h0f, 5'h0b) ##1 s_rd(8'h04)
    |-> prdata[1:0] == 2'h1) else $error("carry not cleared");
  a_rung_idle: assert property (s_cmd(5'h08, 5'h00) ##1 s_rd(8'h04)
    |-> !prdata[0]) else $error("rung out high while idle");
  a_enc_fault: assert property (s_cmd(5'h0f, 5'h0c) ##1 s_rd(8'h04)
    |-> prdata[0] || prdata[2]) else $error("empty table without fault");
  a_word_high: assert property (s_cmd(5'h1f, 5'h18) ##1 s_rd(da)
    |-> prdata == 32'h0000ffff) else $error("word not all ones");
  a_word_low: assert property (s_cmd(5'h1f, 5'h19) ##1 s_rd(da)
    |-> prdata == 32'h0) else $error("word not zero");
  a_bit_high: assert property (s_cmd(5'h1f, 5'h08) ##1 s_rd(da)
    |-> prdata[cmd_q.dst_bit]) else $error("bit not set");
  a_bit_low: assert property (s_cmd(5'h1f, 5'h09) ##1 s_rd(da)
    |-> !prdata[cmd_q.dst_bit]) else $error("bit not cleared");
  a_ready_access: assert property (psel && penable |-> pready)
    else $error("access without ready");
  a_err_idle: assert property (!(psel && penable) |-> !pslverr)
    else $error("error flag outside access");
endmodule

bind bme_exec bme_exec_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

`default_nettype wire

/* verification/bme_exec_tb_top.sv */
// self-checking bench of the bit manipulation execution unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
  begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end

module bme_exec_tb_top;
  import bme_pkg::*;

  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam logic [31:0] F = 32'hffff_ffff;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  wire logic [31:0] prdata;
  wire logic   pready;
  wire logic   pslverr;
  wire logic   irq;
  int          error_cnt = 0;
  int          samples_checked = 0;
  logic [31:0] rs = 32'h007c;
  logic [64:0] q[$];
  logic [64:0] ent;
  logic [31:0] v, t, tm, e, r;
  int          idx;

  always #10 pclk = ~pclk;

  bme_exec dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq));

  // ---------------------------------------------------------------
  // helpers and bus tasks
  // ---------------------------------------------------------------
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  function automatic logic [7:0] da(input logic [3:0] w);
    return 8'h40 + {2'h0, w, 2'h0};
  endfunction

  function automatic logic [31:0] cm(input logic [2:0] op, input logic rg, input logic w,
    input logic [3:0] n, input logic [3:0] s, input logic [3:0] dw, input logic [3:0] b);
    return {11'h0, b, dw, s, n, w, rg, op};
  endfunction

  task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xf(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m,
    input logic er);
    q.push_back({er, m, x});
    xf(1'b0, a, 32'h0);
  endtask

  task automatic idle();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wrap_up();
    if (error_cnt == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // read monitor
  // ---------------------------------------------------------------
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite)
    begin
      ent = q.pop_front();
      `CHK({pslverr, prdata & ent[63:32]}, {ent[64], ent[31:0]})
    end

  initial
  begin
    #200us;
    error_cnt++;
    wrap_up();
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(8'h04, 32'h0, F, 1'b0);
    rd(8'h0c, 32'h0, F, 1'b0);
    rd(8'h4c, 32'h0, F, 1'b0);
    wr(8'h20, F);
    rd(8'h20, 32'h0, F, 1'b1);
    rd(8'h42, 32'h0, F, 1'b1);
    for (int i = 2; i < 4; i++)
    begin
      wr(8'h00, cm(i[2:0], 1'b1, 1'b0, 4'h0, 4'h0, 4'h0, 4'h0));
      rd(8'h04, {30'h0, i == 2, 1'b1}, 32'h3, 1'b0);
    end
    wr(8'h00, cm(3'h2, 1'b0, 1'b0, 4'h0, 4'h0, 4'h0, 4'h0));
    rd(8'h04, 32'h0, 32'h3, 1'b0);
    wr(8'h00, cm(3'h7, 1'b1, 1'b0, 4'h0, 4'h0, 4'h0, 4'h0));
    rd(8'h04, 32'h4, 32'h5, 1'b0);
    wr(8'h04, 32'h0);
    for (int k = 0; k < 4; k++)
    begin
      r = rnd();
      wr(8'h00, cm(3'h0, 1'b1, 1'b1, 4'h0, 4'h0, r[3:0], r[7:4]));
      rd(da(r[3:0]), 32'hffff, F, 1'b0);
      wr(8'h00, cm(3'h1, 1'b1, 1'b0, 4'h0, 4'h0, r[3:0], r[7:4]));
      rd(da(r[3:0]), {16'h0, ~(16'h1 << r[7:4])}, F, 1'b0);
      wr(8'h00, cm(3'h1, 1'b1, 1'b1, 4'h0, 4'h0, r[3:0], r[7:4]));
      rd(da(r[3:0]), 32'h0, F, 1'b0);
      wr(8'h00, cm(3'h0, 1'b1, 1'b0, 4'h0, 4'h0, r[3:0], r[7:4]));
      rd(da(r[3:0]), {16'h0, 16'h1 << r[7:4]}, F, 1'b0);
      wr(8'h00, cm(3'h0, 1'b0, 1'b1, 4'h0, 4'h0, r[3:0], r[7:4]));
      rd(da(r[3:0]), {16'h0, 16'h1 << r[7:4]}, F, 1'b0);
      wr(da(4'h2), r[31:16]);
      wr(8'h00, cm(3'h6, 1'b1, 1'b0, 4'h0, 4'h2, 4'h3, 4'h0));
      rd(da(4'h3), $countones(r[31:16]), F, 1'b0);
    end
    for (int n = 1; n < 6; n++)
    begin
      v = rnd();
      if (n == 2)
        v = v & ~32'hf;
      tm = (n == 5) ? F : (32'h1 << (1 << n)) - 32'h1;
      t = v & tm;
      for (int j = 0; j < 32; j++)
        if (t[j])
          idx = j;
      wr(da(4'h0), v[15:0]);
      wr(da(4'h1), v[31:16]);
      wr(da(4'h4), 32'h1234);
      wr(8'h00, cm(3'h4, 1'b1, 1'b0, n[3:0], 4'h0, 4'h4, 4'h0));
      rd(8'h04, {29'h0, t == 0, 1'b0, t != 0}, 32'h5, 1'b0);
      rd(da(4'h4), (t == 0) ? 32'h1234 : idx, F, 1'b0);
      wr(8'h04, 32'h0);
      wr(da(4'h6), 32'hffff);
      wr(da(4'h7), 32'hffff);
      wr(8'h00, cm(3'h5, 1'b1, 1'b0, n[3:0], 4'h0, 4'h6, 4'h0));
      e = (F & ~tm) | (32'h1 << (v[4:0] & ((5'h1 << n) - 5'h1)));
      rd(da(4'h6), {16'h0, e[15:0]}, F, 1'b0);
      rd(da(4'h7), {16'h0, e[31:16]}, F, 1'b0);
    end
    rd(8'h08, 32'h3, F, 1'b0);
    wr(8'h0c, 32'h1);
    wr(8'h00, cm(3'h2, 1'b1, 1'b0, 4'h0, 4'h0, 4'h0, 4'h0));
    idle();
    `CHK(irq, 1'b1)
    rd(8'h08, 32'h1, F, 1'b0);
    idle();
    `CHK(irq, 1'b0)
    wr(8'h0c, 32'h2);
    wr(8'h00, cm(3'h7, 1'b1, 1'b0, 4'h0, 4'h0, 4'h0, 4'h0));
    idle();
    `CHK(irq, 1'b1)
    rd(8'h08, 32'h3, F, 1'b0);
    idle();
    `CHK(irq, 1'b0)
    repeat (2) @(posedge pclk);
    wrap_up();
  end
endmodule

`default_nettype wire
